// ===== design/ccp_map.svh
// register offsets and codes of the capture/compare/pwm unit
`ifndef CCP_MAP_SVH
`define CCP_MAP_SVH
`define OFS_MODE   4'h0
`define OFS_DUTYH  4'h1
`define OFS_CAPH   4'h2
`define OFS_TBSA   4'h3
`define OFS_TBSB   4'h4
`define OFS_ASD    4'h5
`define OFS_EPWM   4'h6
`define OFS_STAT   4'h7
`define OFS_SYNC   4'h8
`define RST_BYTE   8'h00
`define M_OFF      4'h0
`define M_TOGGLE   4'h2
`define M_CAPF     4'h4
`define M_CAPR     4'h5
`define M_CAP4     4'h6
`define M_CAP16    4'h7
`define M_SETHI    4'h8
`define M_SETLO    4'h9
`define M_SWINT    4'hA
`define M_SPEV     4'hB
`define PRE4_LAST  4'h3
`define PRE16_LAST 4'hF
`define BR_SINGLE  2'h0
`define BR_FWD     2'h1
`define BR_HALF    2'h2
`define BR_REV     2'h3
`define SS_LOW     2'h0
`define IC_LAST    2'h3
`define HTRANS_NSQ 2'h2
`endif

// ===== design/ccp_pkg.sv
// state type of the capture/compare/pwm unit
package ccp_pkg;
   typedef struct packed {
      logic [7:0]  con;
      logic [7:0]  dutyh;
      logic [7:0]  caph;
      logic [7:0]  tbsa;
      logic [1:0]  tbsb;
      logic [7:0]  asd;
      logic [7:0]  epwm;
      logic        ifl;
      logic [1:0]  syncen;
      logic        a_act;
      logic        a_wr;
      logic [3:0]  a_idx;
      logic [31:0] rdata;
      logic [3:0]  s1;
      logic [3:0]  s2;
      logic        cap_p;
      logic [1:0]  cmp_al;
      logic [3:0]  presc;
      logic        cmp_pin;
      logic        match_p;
      logic [9:0]  duty;
      logic        raw_p;
      logic [6:0]  dly;
      logic [1:0]  ic;
      logic [3:0]  lvl;
      logic [3:0]  oe;
      logic        sev;
      logic        adc;
   } state_t;
endpackage

// ===== design/ccp_unit.sv
// capture/compare/pwm unit with enhanced bridge pwm and auto-shutdown
`include "ccp_map.svh"
// Overview of operation
// - mode 0000 turns capture, compare and pwm off and resets the unit
// - mode 0100 captures timer on falling input edge, 0101 on rising edge
// - mode 0110 captures every 4th rising edge, 0111 every 16th
// - mode 0010 toggles the compare pin on each match
// - mode 1000 starts pin low, sets it high on match, sets flag
// - mode 1001 starts pin high, drives it low on match, sets flag
// - mode 1010 only sets flag on match, pin returns to port control
// - mode 1011 match resets timer, sets flag, starts enabled conversion
// - enhanced modes 11xx are pwm, low bits give pair polarities, zero active-high
// - simple units treat 11xx as plain pwm without bridge bits
// - outside pwm, A is capture/compare pin, B C D are port pins
// - bridge 00 modulates only A, B C D stay port pins
// - bridge 10 drives A and B complementary with dead-band
// - bridge 01 modulates D, A active; 11 modulates B, C active
// - duty is 10 bits: low two from mode register, upper from duty byte
// - per-unit 2-bit time base select: 00, 01, 10 timers, 11 reserved
// - fifth unit selector in bits 1-0 of own register, rest read zero
// - shutdown source picks comparator one, two, either, int pin, or mixes
// - in shutdown A and C go low, high or released per state field
// - in shutdown B and D follow their own state field likewise
// - with restart enabled, status clears itself once the condition ends
// - each active-going pwm edge is delayed by the 7-bit instruction count
// - synchronised comparator shutdown waits for the slow timer tick
// - shutdown touches only pins that currently carry pwm
module ccp_unit #(
   parameter bit ENHANCED = 1'b1
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // timers and events
   input  wire logic [15:0] tmr_value,
   input  wire logic [9:0]  pwm_tb_count,
   input  wire logic        pwm_period_start,
   input  wire logic        slow_timer_tick,
   input  wire logic        adc_enabled,
   output logic      [9:0]  time_base_sel,
   output logic             special_event_reset,
   output logic             adc_start,
   output logic             unit_interrupt_flag,
   // async pins
   input  wire logic        capture_in,
   input  wire logic        cmp1_out,
   input  wire logic        cmp2_out,
   input  wire logic        int_pin,
   // output pins a..d in bit order
   output logic      [3:0]  pin_out,
   output logic      [3:0]  pin_oe
);
   ccp_pkg::state_t s_q, s_d;

   logic [3:0] mode;
   logic [1:0] br;
   logic       pwm_m, dphase, wr_con, wr_as, cap_r, cap_f, cap_hit;
   logic       match, mr, cmp_m, c1e, c2e, evt, raw, mod_p, mod_n, ic_en;
   logic [3:0] act, on, pol;

   always_comb begin
      mode    = s_q.con[3:0];
      br      = ENHANCED ? s_q.con[7:6] : `BR_SINGLE;
      pwm_m   = (mode[3:2] == 2'b11);
      dphase  = s_q.a_act;
      wr_con  = dphase && s_q.a_wr && (s_q.a_idx == `OFS_MODE);
      wr_as   = dphase && s_q.a_wr && (s_q.a_idx == `OFS_ASD);
      ic_en   = (s_q.ic == `IC_LAST);
      cap_r   = s_q.s2[0] && !s_q.cap_p;
      cap_f   = !s_q.s2[0] && s_q.cap_p;
      match   = (tmr_value == {s_q.caph, s_q.dutyh});
      mr      = match && !s_q.match_p;
      cmp_m   = (mode == `M_TOGGLE) || (mode[3:2] == 2'b10);
      c1e     = s_q.syncen[0] ? s_q.cmp_al[0] : s_q.s2[1];
      c2e     = s_q.syncen[1] ? s_q.cmp_al[1] : s_q.s2[2];
      evt     = (s_q.asd[4] && c1e) || (s_q.asd[5] && c2e) || (s_q.asd[6] && !s_q.s2[3]);
      cap_hit = 1'b0;
      unique case (mode)
         `M_CAPF:  cap_hit = cap_f;
         `M_CAPR:  cap_hit = cap_r;
         `M_CAP4:  cap_hit = cap_r && (s_q.presc == `PRE4_LAST);
         `M_CAP16: cap_hit = cap_r && (s_q.presc == `PRE16_LAST);
         default:  cap_hit = 1'b0;
      endcase
      raw   = pwm_tb_count < s_q.duty;
      mod_p = raw && (s_q.dly >= s_q.epwm[6:0]);
      mod_n = !raw && (s_q.dly >= s_q.epwm[6:0]);
      pol   = ENHANCED ? {mode[0], mode[1], mode[0], mode[1]} : 4'h0;
      act   = 4'h0;
      on    = 4'h0;
      if (pwm_m) begin
         unique case (br)
            `BR_SINGLE: begin
               act = {3'b000, mod_p};
               on  = 4'b0001;
            end
            `BR_HALF: begin
               act = {2'b00, mod_n, mod_p};
               on  = 4'b0011;
            end
            `BR_FWD: begin
               act = {mod_p, 3'b001};
               on  = 4'b1111;
            end
            `BR_REV: begin
               act = {2'b01, mod_p, 1'b0};
               on  = 4'b1111;
            end
         endcase
      end
   end

   always_comb begin
      s_d     = s_q;
      s_d.sev = 1'b0;
      s_d.adc = 1'b0;
      s_d.s1  = {int_pin, cmp2_out, cmp1_out, capture_in};
      s_d.s2  = s_q.s1;
      s_d.cap_p   = s_q.s2[0];
      s_d.match_p = match;
      s_d.ic  = s_q.ic + 2'h1;
      if (slow_timer_tick) begin
         s_d.cmp_al = s_q.s2[2:1];
      end
      // bus data phase
      if (dphase && s_q.a_wr) begin
         unique case (s_q.a_idx)
            `OFS_MODE:  s_d.con = ENHANCED ? hwdata[7:0] : {2'b00, hwdata[5:0]};
            `OFS_DUTYH: s_d.dutyh = hwdata[7:0];
            `OFS_CAPH:  s_d.caph = hwdata[7:0];
            `OFS_TBSA:  s_d.tbsa = hwdata[7:0];
            `OFS_TBSB:  s_d.tbsb = hwdata[1:0];
            `OFS_ASD:   s_d.asd = hwdata[7:0];
            `OFS_EPWM:  s_d.epwm = hwdata[7:0];
            `OFS_STAT:  s_d.ifl = s_q.ifl && !hwdata[0];
            `OFS_SYNC:  s_d.syncen = hwdata[1:0];
            default:    s_d.ifl = s_d.ifl;
         endcase
      end
      if (wr_con && hwdata[3:0] == `M_SETHI) begin
         s_d.cmp_pin = 1'b0;
      end
      if (wr_con && hwdata[3:0] == `M_SETLO) begin
         s_d.cmp_pin = 1'b1;
      end
      // capture
      if (mode == `M_CAP4 || mode == `M_CAP16) begin
         if (cap_hit) begin
            s_d.presc = 4'h0;
         end else if (cap_r) begin
            s_d.presc = s_q.presc + 4'h1;
         end
      end
      if (cap_hit) begin
         {s_d.caph, s_d.dutyh} = tmr_value;
         s_d.ifl = 1'b1;
      end
      // compare
      if (mr && cmp_m) begin
         unique case (mode)
            `M_TOGGLE: s_d.cmp_pin = !s_q.cmp_pin;
            `M_SETHI: begin
               s_d.cmp_pin = 1'b1;
               s_d.ifl = 1'b1;
            end
            `M_SETLO: begin
               s_d.cmp_pin = 1'b0;
               s_d.ifl = 1'b1;
            end
            `M_SWINT:  s_d.ifl = 1'b1;
            `M_SPEV: begin
               s_d.ifl = 1'b1;
               s_d.sev = 1'b1;
               s_d.adc = adc_enabled;
            end
            default:   s_d.ifl = 1'b1;
         endcase
      end
      // pwm duty latched per period to avoid glitched pulses
      if (pwm_period_start) begin
         s_d.duty = {s_q.dutyh, s_q.con[5:4]};
      end
      if (raw != s_q.raw_p) begin
         s_d.dly = 7'h00;
      end else if (ic_en && s_q.dly != 7'h7F) begin
         s_d.dly = s_q.dly + 7'h01;
      end
      s_d.raw_p = raw;
      // shutdown status, set wins over software clear
      if (ENHANCED && s_q.asd[7] && s_q.epwm[7] && !evt) begin
         s_d.asd[7] = 1'b0;
      end
      if (ENHANCED && evt) begin
         s_d.asd[7] = 1'b1;
      end
      // pins
      for (int i = 0; i < 4; i++) begin
         s_d.lvl[i] = act[i] ^ pol[i];
         s_d.oe[i]  = on[i];
         if (on[i] && s_q.asd[7]) begin
            if (i == 0 || i == 2) begin
               s_d.lvl[i] = s_q.asd[2];
               s_d.oe[i]  = !s_q.asd[3];
            end else begin
               s_d.lvl[i] = s_q.asd[0];
               s_d.oe[i]  = !s_q.asd[1];
            end
         end
      end
      if (!pwm_m) begin
         s_d.lvl = {3'b000, s_q.cmp_pin};
         s_d.oe  = {3'b000, (mode == `M_TOGGLE) || (mode[3:1] == 3'b100)};
      end
      if (mode == `M_OFF) begin
         s_d.presc   = 4'h0;
         s_d.cmp_pin = 1'b0;
         s_d.dly     = 7'h00;
         s_d.lvl     = 4'h0;
         s_d.oe      = 4'h0;
      end
      // bus address phase
      s_d.a_act = hsel && hready && (htrans == `HTRANS_NSQ);
      s_d.a_wr  = hwrite;
      s_d.a_idx = haddr[5:2];
      if (hsel && hready && (htrans == `HTRANS_NSQ) && !hwrite) begin
         unique case (haddr[5:2])
            `OFS_MODE:  s_d.rdata = {24'h0, s_q.con};
            `OFS_DUTYH: s_d.rdata = {24'h0, s_q.dutyh};
            `OFS_CAPH:  s_d.rdata = {24'h0, s_q.caph};
            `OFS_TBSA:  s_d.rdata = {24'h0, s_q.tbsa};
            `OFS_TBSB:  s_d.rdata = {30'h0, s_q.tbsb};
            `OFS_ASD:   s_d.rdata = {24'h0, s_q.asd};
            `OFS_EPWM:  s_d.rdata = {24'h0, s_q.epwm};
            `OFS_STAT:  s_d.rdata = {31'h0, s_q.ifl};
            `OFS_SYNC:  s_d.rdata = {30'h0, s_q.syncen};
            default:    s_d.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign hrdata              = s_q.rdata;
   assign hreadyout           = 1'b1;
   assign hresp               = 1'b0;
   assign time_base_sel       = {s_q.tbsb, s_q.tbsa};
   assign special_event_reset = s_q.sev;
   assign adc_start           = s_q.adc;
   assign unit_interrupt_flag = s_q.ifl;
   assign pin_out             = s_q.lvl;
   assign pin_oe              = s_q.oe;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_mode_off_pins: assert property (mode == `M_OFF |=> pin_oe == 4'h0)
      else $error("pins driven while unit off");
   a_capture_fall: assert property (mode == `M_CAPF && cap_f && !dphase
      |=> {s_q.caph, s_q.dutyh} == $past(tmr_value) && s_q.ifl)
      else $error("falling capture missed");
   a_toggle_pin: assert property (mode == `M_TOGGLE && mr && !wr_con
      |=> s_q.cmp_pin != $past(s_q.cmp_pin))
      else $error("compare pin did not toggle");
   a_sethi_match: assert property (mode == `M_SETHI && mr && !wr_con
      |=> s_q.cmp_pin && s_q.ifl ##1 pin_out[0])
      else $error("set on match failed");
   a_spev_pulse: assert property (mode == `M_SPEV && mr
      |=> special_event_reset ##1 !special_event_reset)
      else $error("special event not a single pulse");
   a_shdn_set: assert property (ENHANCED && evt |=> s_q.asd[7])
      else $error("shutdown event lost");
   a_auto_restart: assert property (ENHANCED && s_q.asd[7] && s_q.epwm[7] && !evt && !wr_as
      |=> !s_q.asd[7])
      else $error("auto restart did not clear status");
   a_shdn_pin_a: assert property (pwm_m && on[0] && s_q.asd[7] && s_q.asd[3:2] == `SS_LOW
      |=> pin_oe[0] && !pin_out[0])
      else $error("pin a not in shutdown state");
   a_setlo_match: assert property (mode == `M_SETLO && mr && !wr_con
      |=> !s_q.cmp_pin && s_q.ifl)
      else $error("clear on match failed");
   a_swint_flag: assert property (mode == `M_SWINT && mr
      |=> s_q.ifl && !pin_oe[0])
      else $error("software interrupt compare wrong");
   a_adc_gate: assert property (adc_start |-> $past(adc_enabled))
      else $error("conversion started while converter off");
   a_cap_rise: assert property (mode == `M_CAPR && cap_r && !dphase
      |=> {s_q.caph, s_q.dutyh} == $past(tmr_value) && s_q.ifl)
      else $error("rising capture missed");
   a_presc_wrap: assert property (mode == `M_CAP4 && cap_r && s_q.presc == `PRE4_LAST
      |=> s_q.presc == 4'h0)
      else $error("prescaler did not wrap");
   a_nonpwm_ports: assert property (!pwm_m |=> pin_oe[3:1] == 3'b000)
      else $error("port pins driven outside pwm");
   a_single_ports: assert property (pwm_m && br == `BR_SINGLE
      |=> pin_oe[3:1] == 3'b000)
      else $error("single output drives extra pins");
   // complement check only without delay: dead band makes both inactive briefly
   a_half_pair: assert property (pwm_m && br == `BR_HALF && !s_q.asd[7] && s_q.epwm[6:0] == 7'h00
      |=> (pin_out[0] ^ pin_out[1]) != ($past(mode[0]) ^ $past(mode[1])))
      else $error("half bridge pair not complementary");
   a_fwd_bridge: assert property (pwm_m && br == `BR_FWD && !s_q.asd[7]
      |=> pin_oe == 4'hF && pin_out[0] != pin_out[2])
      else $error("forward bridge pins wrong");
   a_shdn_pin_b: assert property (pwm_m && on[1] && s_q.asd[7] && s_q.asd[1]
      |=> !pin_oe[1])
      else $error("pin b not released in shutdown");
   // duty taken only at period start so a write never splits a pulse
   a_duty_latch: assert property (pwm_period_start
      |=> s_q.duty == {$past(s_q.dutyh), $past(s_q.con[5:4])})
      else $error("duty not latched at period start");
endmodule

// ===== verif/bridge_stage.sv
// power stage model: resolves each output pin to its wire level
module bridge_stage (
   // pins from the unit
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe,
   // resolved levels
   output logic      [3:0] level
);
   timeunit 1ns;
   timeprecision 1ps;
   // released pins fall to the pull-downs that keep the switches off
   always_comb level = (pin_out & pin_oe) | 4'h0;
endmodule

// ===== verif/tb_ccp_mode_and_epwm_control.sv
// self-checking bench of the capture/compare/pwm unit
`include "ccp_map.svh"
module tb_ccp_mode_and_epwm_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pps = 0;
   logic        cmp1 = 0, cmp2 = 0, int_pin = 1;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
   logic [9:0]  cnt = 10'h000, tbs;
   logic [3:0]  pin_out, pin_oe, level;
   logic        hreadyout;
   logic [15:0] tmr = 16'h0000;
   logic        cap_in = 0, tick = 0, adce = 0, flag, sev, adc;
   int          n_mismatch = 0, comparisons = 0;
   always #10 hclk = ~hclk;
   ccp_unit DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
      .tmr_value(tmr), .pwm_tb_count(cnt), .pwm_period_start(pps),
      .slow_timer_tick(tick), .adc_enabled(adce), .time_base_sel(tbs),
      .special_event_reset(sev), .adc_start(adc), .unit_interrupt_flag(flag),
      .capture_in(cap_in), .cmp1_out(cmp1), .cmp2_out(cmp2), .int_pin(int_pin),
      .pin_out(pin_out), .pin_oe(pin_oe));
   bridge_stage stage (.pin_out(pin_out), .pin_oe(pin_oe), .level(level));
   task automatic chk(input string n, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // one single word transfer; entered right after a rising edge
   task automatic xfer(input logic w, input logic [3:0] idx, input logic [31:0] d);
      hsel <= 1;
      haddr <= {26'h0, idx, 2'h0};
      htrans <= `HTRANS_NSQ;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask
   task automatic wr(input logic [3:0] idx, input logic [31:0] d);
      xfer(1'b1, idx, d);
   endtask
   task automatic rdc(input string n, input logic [3:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 32'h0);
      chk(n, r, exp);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic reset_values();
      rdc("mode", `OFS_MODE, 32'h0);
      rdc("tbsa", `OFS_TBSA, 32'h0);
      rdc("tbsb", `OFS_TBSB, 32'h0);
      rdc("asd", `OFS_ASD, 32'h0);
      rdc("epwm", `OFS_EPWM, 32'h0);
      rdc("unmapped", 4'hC, 32'h0);
   endtask
   task automatic time_base();
      wr(`OFS_TBSA, 32'h24);
      wr(`OFS_TBSB, 32'hFF);
      rdc("tbsa", `OFS_TBSA, 32'h24);
      rdc("tbsb", `OFS_TBSB, 32'h03);
      chk("tbsel", {22'h0, tbs}, 32'h324);
   endtask
   task automatic single_pwm();
      wr(`OFS_MODE, 32'h83); // non-pwm mode with bridge bits set
      wait_n(3);
      chk("oe nonpwm", {29'h0, pin_oe[3:1]}, 32'h0);
      wr(`OFS_DUTYH, 32'h10);
      wr(`OFS_MODE, 32'h1C);
      pps <= 1;
      cnt <= 10'h040;
      @(posedge hclk);
      pps <= 0;
      wait_n(5);
      chk("a high", {27'h0, pin_out[0], pin_oe}, 32'h11);
      cnt <= 10'h041;
      wait_n(5);
      chk("a low", {31'h0, pin_out[0]}, 32'h0);
   endtask
   task automatic shutdown();
      wr(`OFS_ASD, 32'h46); // int pin low; a/c high, b/d released
      wr(`OFS_MODE, 32'h9C);
      wait_n(4);
      chk("half", {24'h0, pin_out, pin_oe}, 32'h23);
      int_pin <= 0;
      wait_n(8);
      chk("sd lvl", {28'h0, level}, 32'h1);
      chk("sd oe", {28'h0, pin_oe}, 32'h1);
      int_pin <= 1;
      wait_n(8);
      rdc("sticky", `OFS_ASD, 32'hC6);
      wr(`OFS_ASD, 32'h36); // software clear, either comparator
      rdc("cleared", `OFS_ASD, 32'h36);
      wr(`OFS_EPWM, 32'h80);
      cmp2 <= 1;
      wait_n(8);
      rdc("cmp2 sd", `OFS_ASD, 32'hB6);
      cmp2 <= 0;
      wait_n(8);
      rdc("restart", `OFS_ASD, 32'h36);
      chk("resumed", {28'h0, pin_oe}, 32'h3);
      wr(`OFS_SYNC, 32'h2);
      cmp2 <= 1;
      wait_n(8);
      rdc("sync hold", `OFS_ASD, 32'h36);
      tick <= 1;
      @(posedge hclk);
      tick <= 0;
      wait_n(3);
      rdc("sync sd", `OFS_ASD, 32'hB6);
      cmp2 <= 0;
      wait_n(4);
      tick <= 1;
      @(posedge hclk);
      tick <= 0;
      wait_n(3);
      rdc("sync restart", `OFS_ASD, 32'h36);
      wr(`OFS_SYNC, 32'h0);
      wr(`OFS_MODE, 32'h0);
      wait_n(3);
      chk("off", {28'h0, pin_oe}, 32'h0);
   endtask
   task automatic compare();
      int n_sev = 0;
      int n_adc = 0;
      wr(`OFS_CAPH, 32'h12);
      wr(`OFS_DUTYH, 32'h34);
      wr(`OFS_MODE, 32'h08);
      wait_n(3);
      chk("sethi init", {30'h0, pin_out[0], pin_oe[0]}, 32'h1);
      tmr <= 16'h1234;
      wait_n(4);
      chk("sethi pin", {30'h0, pin_out[0], flag}, 32'h3);
      tmr <= 16'h0000;
      wr(`OFS_STAT, 32'h1);
      wr(`OFS_MODE, 32'h09);
      wait_n(3);
      chk("setlo init", {30'h0, pin_out[0], flag}, 32'h2);
      tmr <= 16'h1234;
      wait_n(4);
      chk("setlo pin", {30'h0, pin_out[0], flag}, 32'h1);
      tmr <= 16'h0000;
      wr(`OFS_STAT, 32'h1);
      wr(`OFS_MODE, 32'h02);
      tmr <= 16'h1234;
      wait_n(4);
      chk("toggle 1", {31'h0, pin_out[0]}, 32'h1);
      tmr <= 16'h0000;
      wait_n(2);
      tmr <= 16'h1234;
      wait_n(4);
      chk("toggle 2", {31'h0, pin_out[0]}, 32'h0);
      tmr <= 16'h0000;
      wr(`OFS_MODE, 32'h0A);
      tmr <= 16'h1234;
      wait_n(4);
      chk("swint", {30'h0, pin_oe[0], flag}, 32'h1);
      tmr <= 16'h0000;
      wr(`OFS_STAT, 32'h1);
      adce <= 1;
      wr(`OFS_MODE, 32'h0B);
      tmr <= 16'h1234;
      repeat (6) begin
         @(negedge hclk);
         n_sev += sev;
         n_adc += adc;
      end
      chk("spev", {n_sev[15:0], n_adc[15:0]}, 32'h00010001);
      chk("spev flag", {31'h0, flag}, 32'h1);
      @(posedge hclk);
      tmr <= 16'h0000;
      adce <= 0;
      wr(`OFS_STAT, 32'h1);
      rdc("status", `OFS_STAT, 32'h0);
   endtask
   task automatic pulse_cap();
      cap_in <= 1;
      wait_n(4);
      cap_in <= 0;
      wait_n(4);
   endtask
   task automatic capture();
      wr(`OFS_MODE, 32'h05);
      tmr <= 16'hABCD;
      cap_in <= 1;
      wait_n(6);
      rdc("cap rise h", `OFS_CAPH, 32'hAB);
      rdc("cap rise l", `OFS_DUTYH, 32'hCD);
      wr(`OFS_MODE, 32'h04);
      tmr <= 16'h5A5A;
      cap_in <= 0;
      wait_n(6);
      rdc("cap fall", `OFS_CAPH, 32'h5A);
      chk("cap flag", {31'h0, flag}, 32'h1);
      wr(`OFS_MODE, 32'h06);
      tmr <= 16'h0C0C;
      repeat (3) pulse_cap();
      rdc("cap4 early", `OFS_CAPH, 32'h5A);
      pulse_cap();
      rdc("cap4", `OFS_CAPH, 32'h0C);
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // a hang would otherwise stall the run forever
   initial begin
      repeat (20000) @(posedge hclk);
      n_mismatch++;
      wrap_up();
   end
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      reset_values();
      time_base();
      single_pwm();
      shutdown();
      compare();
      capture();
      wrap_up();
   end
endmodule
